// *** pkg/tmr_defines.svh ***
/*
  Constants for the dual 8-bit cascadable timer: register offsets, control
  field positions, reset values, source clock exponents and mode codes.
  Assumes inclusion by bare name from the design and testbench files.
*/
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TMR_OFF_CTRL_A 8'h20
`define TMR_OFF_CTRL_B 8'h21
`define TMR_OFF_SYS 8'h22
`define TMR_OFF_PER_A 8'h24
`define TMR_OFF_DUTY_A 8'h25
`define TMR_OFF_PER_B 8'h26
`define TMR_OFF_DUTY_B 8'h27
`define TMR_OFF_STATUS 8'h28
`define TMR_OFF_MASK 8'h29

// ----------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------
`define TMR_FF_BIT 7
`define TMR_CK_HI 6
`define TMR_CK_LO 4
`define TMR_RUN_BIT 3
`define TMR_MODE_HI 2
`define TMR_MODE_LO 0
`define TMR_HALVE_BIT 0
`define TMR_CTRL_RST 8'h00
`define TMR_CMP_RST 8'hFF
`define TMR_ZERO8 8'h00
`define TMR_ONES8 8'hFF
`define TMR_ONES16 16'hFFFF
`define TMR_IRQ_A 0
`define TMR_IRQ_B 1

// ----------------------------------------------------------------------
// Source clock codes and divider exponents
// ----------------------------------------------------------------------
`define TMR_CK_DIV11 3'h0
`define TMR_CK_DIV7 3'h1
`define TMR_CK_DIV5 3'h2
`define TMR_CK_DIV3 3'h3
`define TMR_CK_PIN 3'h7
`define TMR_EXP11 4'hB
`define TMR_EXP7 4'h7
`define TMR_EXP5 4'h5
`define TMR_EXP3 4'h3
`define TMR_EXP_ONE 4'h1
`define TMR_PRE_W 13

// ----------------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------------
`define TMR_M_TIMER 3'h0
`define TMR_M_DIV 3'h1
`define TMR_M_PWM 3'h2
`define TMR_M_CASC 3'h3
`define TMR_M_T16 3'h4
`define TMR_M_WARM 3'h5
`define TMR_M_PWM16 3'h6
`define TMR_M_PPG 3'h7

`endif

// *** pkg/tmr_pkg.sv ***
/*
  Types shared by the timer design files.
  Assumes nothing of its surroundings.
*/
package tmr_pkg;
	typedef logic [7:0] tmr_byte_t;
	typedef logic [7:0] tmr_addr_t;
	typedef logic [15:0] tmr_word_t;
endpackage

// *** rtl/tmr_edge_sync.sv ***
/*
  Two-flop synchroniser for an event pin with a falling-edge pulse.
  Assumes the pin is asynchronous to ref_clk and holds each level two cycles.
*/
`timescale 1ns/1ps
module tmr_edge_sync (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic pin,
	output logic fall
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	// ------------------------------------------------------------------
	// Synchroniser and edge detector.
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			last_reg <= 1'b1;
		end else begin
			meta_reg <= pin;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign fall = last_reg & ~sync_reg;
endmodule // tmr_edge_sync

// *** rtl/tmr_top.sv ***
/*
  Two 8-bit timer/counters, cascadable into one 16-bit counter, with their
  control and compare registers, prescaler, pulse outputs and interrupt.
  Assumes a simple register port on ref_clk and asynchronous event pins.
*/
// Added by the designer: the address-and-strobe port.
// What this block does
// - Counter A control: flip-flop bit 7, clock 6:4, run 3, mode 2:0, reset zero.
// - Counter B control uses the same layout at its own address.
// - A clock codes 0-3 give fc/2^11,7,5,3, halved optionally; 7 is pin.
// - B clock codes give the same dividers, halved optionally only for codes 0-1; code 7 is its own pin.
// - Clearing run stops the counter; setting it restarts from zero.
// - A mode 1 divider output, 2 PWM, 3 cascaded under counter B.
// - B modes: 0 timer/event, 1 divider, 2 PWM, 4 16-bit, 5 warm-up, 6 PWM16.
// - Cascaded: clock from A select, run and flip-flop from counter B.
// - A stopping write keeps mode, clock, flip-flop; a starting write may set them.
// - Duty compare may be written in any mode; its shadow reloads at start and on each match or overflow.
// - Each counter has a period and a duty 8-bit compare register.
// - Timer mode: match on period raises interrupt and clears the counter.
// - Event mode counts on each falling edge of the event pin.
// - Flip-flops reset to zero; divider pin drives the inverted flip-flop.
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tmr_top (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire tmr_pkg::tmr_addr_t addr,
	input wire tmr_pkg::tmr_byte_t wdata,
	input wire logic wr,
	input wire logic rd,
	output tmr_pkg::tmr_byte_t rdata,
	input wire logic counter_a_event_pin,
	input wire logic counter_b_event_pin,
	output logic out_a,
	output logic out_b,
	output logic irq
);
	import tmr_pkg::*;

	tmr_byte_t ctrl_a_reg, ctrl_b_reg, per_a_reg, per_b_reg, duty_a_reg, duty_b_reg;
	tmr_byte_t cnt_a_reg, cnt_b_reg, shd_a_reg, shd_b_reg, rdata_reg;
	logic extra_halving_select_reg, ff_a_reg, ff_b_reg, out_a_reg, out_b_reg, irq_reg;
	logic [1:0] status_reg, mask_reg, status_next;
	logic [`TMR_PRE_W-1:0] pre_reg;
	logic [2:0] mode_a, mode_b, ck_a, ck_b;
	logic run_a, run_b, casc, run_a_eff, tick_a, tick_b, inc_a, inc_b;
	logic fall_a, fall_b, wr_ca, wr_cb, start_a, start_b, match_a, match_b, match16;
	logic ev_a, ev_b;
	logic [3:0] exp_a, exp_b;
	tmr_word_t cnt16, per16, shd16;

	// ------------------------------------------------------------------
	// Event pin synchronisers.
	// ------------------------------------------------------------------
	tmr_edge_sync u_sync_a (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pin(counter_a_event_pin),
		.fall(fall_a)
	);
	tmr_edge_sync u_sync_b (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pin(counter_b_event_pin),
		.fall(fall_b)
	);

	// ------------------------------------------------------------------
	// Field decode and source clocks.
	// ------------------------------------------------------------------
	function automatic logic tick_at(input logic [`TMR_PRE_W-1:0] c, input logic [3:0] e);
		logic [`TMR_PRE_W-1:0] m;
		m = (`TMR_PRE_W'(1) << e) - `TMR_PRE_W'(1);
		tick_at = &(c | ~m);
	endfunction

	function automatic logic [3:0] base_exp(input logic [2:0] ck);
		case (ck)
			`TMR_CK_DIV11: base_exp = `TMR_EXP11;
			`TMR_CK_DIV7: base_exp = `TMR_EXP7;
			`TMR_CK_DIV5: base_exp = `TMR_EXP5;
			default: base_exp = `TMR_EXP3;
		endcase
	endfunction

	assign mode_a = ctrl_a_reg[`TMR_MODE_HI:`TMR_MODE_LO];
	assign mode_b = ctrl_b_reg[`TMR_MODE_HI:`TMR_MODE_LO];
	assign ck_a = ctrl_a_reg[`TMR_CK_HI:`TMR_CK_LO];
	assign ck_b = ctrl_b_reg[`TMR_CK_HI:`TMR_CK_LO];
	assign run_a = ctrl_a_reg[`TMR_RUN_BIT];
	assign run_b = ctrl_b_reg[`TMR_RUN_BIT];
	assign casc = (mode_a == `TMR_M_CASC) && mode_b[2];
	assign run_a_eff = casc ? run_b : run_a;
	assign exp_a = base_exp(ck_a) + (extra_halving_select_reg ? `TMR_EXP_ONE : 4'h0);
	assign exp_b = base_exp(ck_b) + ((extra_halving_select_reg && !ck_b[1]) ? `TMR_EXP_ONE : 4'h0);
	assign tick_a = (ck_a == `TMR_CK_PIN) ? fall_a : (!ck_a[2] && tick_at(pre_reg, exp_a));
	assign tick_b = (ck_b == `TMR_CK_PIN) ? fall_b : (!ck_b[2] && tick_at(pre_reg, exp_b));
	assign inc_a = run_a_eff && tick_a && (casc || mode_a != `TMR_M_CASC);
	assign inc_b = run_b && tick_b && !mode_b[2] && (mode_b != `TMR_M_CASC);
	assign wr_ca = wr && (addr == `TMR_OFF_CTRL_A);
	assign wr_cb = wr && (addr == `TMR_OFF_CTRL_B);
	assign start_a = wr_ca && wdata[`TMR_RUN_BIT] && !run_a;
	assign start_b = wr_cb && wdata[`TMR_RUN_BIT] && !run_b;
	assign match_a = (cnt_a_reg == per_a_reg);
	assign match_b = (cnt_b_reg == per_b_reg);
	assign cnt16 = {cnt_b_reg, cnt_a_reg};
	assign per16 = {per_b_reg, per_a_reg};
	assign shd16 = {shd_b_reg, shd_a_reg};
	assign match16 = (cnt16 == per16);

	// ------------------------------------------------------------------
	// Match and overflow events.
	// ------------------------------------------------------------------
	always_comb begin
		ev_a = 1'b0;
		ev_b = 1'b0;
		if (casc) begin
			if (inc_a) begin
				if (mode_b == `TMR_M_PWM16) begin
					ev_b = (cnt16 == `TMR_ONES16);
				end else begin
					ev_b = match16;
				end
			end
		end else begin
			if (inc_a) begin
				ev_a = (mode_a == `TMR_M_PWM) ? (cnt_a_reg == `TMR_ONES8) : match_a;
			end
			if (inc_b) begin
				ev_b = (mode_b == `TMR_M_PWM) ? (cnt_b_reg == `TMR_ONES8) : match_b;
			end
		end
	end

	// ------------------------------------------------------------------
	// Prescaler.
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_reg <= '0;
		end else begin
			pre_reg <= pre_reg + `TMR_PRE_W'(1);
		end
	end

	// ------------------------------------------------------------------
	// Control and compare registers.
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_a_reg <= `TMR_CTRL_RST;
			ctrl_b_reg <= `TMR_CTRL_RST;
			extra_halving_select_reg <= 1'b0;
			per_a_reg <= `TMR_CMP_RST;
			per_b_reg <= `TMR_CMP_RST;
			duty_a_reg <= `TMR_CMP_RST;
			duty_b_reg <= `TMR_CMP_RST;
			mask_reg <= 2'h0;
		end else if (wr) begin
			case (addr)
				`TMR_OFF_CTRL_A: begin
					if (run_a && !wdata[`TMR_RUN_BIT]) begin
						ctrl_a_reg[`TMR_RUN_BIT] <= 1'b0;
					end else begin
						ctrl_a_reg <= wdata;
					end
				end
				`TMR_OFF_CTRL_B: begin
					if (run_b && !wdata[`TMR_RUN_BIT]) begin
						ctrl_b_reg[`TMR_RUN_BIT] <= 1'b0;
					end else begin
						ctrl_b_reg <= wdata;
					end
				end
				`TMR_OFF_SYS: extra_halving_select_reg <= wdata[`TMR_HALVE_BIT];
				`TMR_OFF_PER_A: per_a_reg <= wdata;
				`TMR_OFF_DUTY_A: duty_a_reg <= wdata;
				`TMR_OFF_PER_B: per_b_reg <= wdata;
				`TMR_OFF_DUTY_B: duty_b_reg <= wdata;
				`TMR_OFF_MASK: mask_reg <= wdata[1:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Counters and duty shadows.
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_a_reg <= `TMR_ZERO8;
			cnt_b_reg <= `TMR_ZERO8;
			shd_a_reg <= `TMR_CMP_RST;
			shd_b_reg <= `TMR_CMP_RST;
		end else begin
			if (start_a || (start_b && mode_a == `TMR_M_CASC && wdata[`TMR_MODE_HI])) begin
				cnt_a_reg <= `TMR_ZERO8;
				shd_a_reg <= duty_a_reg;
			end else if (inc_a) begin
				if (casc && mode_b != `TMR_M_PWM16 && match16) begin
					cnt_a_reg <= `TMR_ZERO8;
				end else if (!casc && mode_a != `TMR_M_PWM && match_a) begin
					cnt_a_reg <= `TMR_ZERO8;
				end else begin
					cnt_a_reg <= cnt_a_reg + 8'h01;
				end
				if (ev_a || ev_b) begin
					shd_a_reg <= duty_a_reg;
				end
			end
			if (start_b) begin
				cnt_b_reg <= `TMR_ZERO8;
				shd_b_reg <= duty_b_reg;
			end else if (casc && inc_a) begin
				if (mode_b != `TMR_M_PWM16 && match16) begin
					cnt_b_reg <= `TMR_ZERO8;
				end else if (cnt_a_reg == `TMR_ONES8) begin
					cnt_b_reg <= cnt_b_reg + 8'h01;
				end
				if (ev_b) begin
					shd_b_reg <= duty_b_reg;
				end
			end else if (inc_b) begin
				if (mode_b != `TMR_M_PWM && match_b) begin
					cnt_b_reg <= `TMR_ZERO8;
				end else begin
					cnt_b_reg <= cnt_b_reg + 8'h01;
				end
				if (ev_b) begin
					shd_b_reg <= duty_b_reg;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Output flip-flops and pulse pins.
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ff_a_reg <= 1'b0;
			ff_b_reg <= 1'b0;
		end else begin
			if (start_a) begin
				ff_a_reg <= wdata[`TMR_FF_BIT];
			end else if (ev_a && mode_a == `TMR_M_DIV) begin
				ff_a_reg <= ~ff_a_reg;
			end
			if (start_b) begin
				ff_b_reg <= wdata[`TMR_FF_BIT];
			end else if (casc && mode_b == `TMR_M_PPG && inc_a) begin
				if (match16) begin
					ff_b_reg <= 1'b0;
				end else if (cnt16 == shd16) begin
					ff_b_reg <= 1'b1;
				end
			end else if (ev_b && !casc && mode_b == `TMR_M_DIV) begin
				ff_b_reg <= ~ff_b_reg;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_a_reg <= 1'b1;
			out_b_reg <= 1'b1;
		end else begin
			if (!run_a_eff || casc) begin
				out_a_reg <= 1'b1;
			end else if (mode_a == `TMR_M_PWM) begin
				out_a_reg <= (cnt_a_reg < shd_a_reg);
			end else begin
				out_a_reg <= ~ff_a_reg;
			end
			if (!run_b) begin
				out_b_reg <= 1'b1;
			end else if (casc && mode_b == `TMR_M_PWM16) begin
				out_b_reg <= (cnt16 < shd16);
			end else if (!casc && mode_b == `TMR_M_PWM) begin
				out_b_reg <= (cnt_b_reg < shd_b_reg);
			end else begin
				out_b_reg <= ~ff_b_reg;
			end
		end
	end

	// ------------------------------------------------------------------
	// Interrupt status, read data and interrupt output.
	// ------------------------------------------------------------------
	always_comb begin
		status_next = status_reg;
		if (rd && addr == `TMR_OFF_STATUS) begin
			status_next = 2'h0;
		end
		status_next[`TMR_IRQ_A] = status_next[`TMR_IRQ_A] | ev_a;
		status_next[`TMR_IRQ_B] = status_next[`TMR_IRQ_B] | ev_b;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= 2'h0;
			irq_reg <= 1'b0;
		end else begin
			status_reg <= status_next;
			irq_reg <= |(status_next & mask_reg);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= `TMR_ZERO8;
		end else if (rd) begin
			case (addr)
				`TMR_OFF_CTRL_A: rdata_reg <= ctrl_a_reg;
				`TMR_OFF_CTRL_B: rdata_reg <= ctrl_b_reg;
				`TMR_OFF_SYS: rdata_reg <= {7'h00, extra_halving_select_reg};
				`TMR_OFF_PER_A: rdata_reg <= per_a_reg;
				`TMR_OFF_DUTY_A: rdata_reg <= duty_a_reg;
				`TMR_OFF_PER_B: rdata_reg <= per_b_reg;
				`TMR_OFF_DUTY_B: rdata_reg <= duty_b_reg;
				`TMR_OFF_STATUS: rdata_reg <= {6'h00, status_reg};
				`TMR_OFF_MASK: rdata_reg <= {6'h00, mask_reg};
				default: rdata_reg <= `TMR_ZERO8;
			endcase
		end else begin
			rdata_reg <= `TMR_ZERO8;
		end
	end

	assign rdata = rdata_reg;
	assign out_a = out_a_reg;
	assign out_b = out_b_reg;
	assign irq = irq_reg;

	// ------------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------------
	chk_ctrl_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_ca && !run_a |=> ctrl_a_reg == $past(wdata))
		else $error("control A write not stored");

	chk_start_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		start_a |=> cnt_a_reg == `TMR_ZERO8 && run_a)
		else $error("start did not clear counter A");

	chk_stop_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_cb && run_b && !wdata[`TMR_RUN_BIT] |=> !run_b && $stable(ctrl_b_reg[7:4])
		&& $stable(mode_b))
		else $error("stopping write altered control fields");

	chk_match_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
		inc_a && !casc && mode_a == `TMR_M_TIMER && match_a && !start_a
		|=> status_reg[`TMR_IRQ_A] && cnt_a_reg == `TMR_ZERO8)
		else $error("timer match missed");

	chk_event_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
		run_b && !casc && mode_b == `TMR_M_TIMER && ck_b == `TMR_CK_PIN && fall_b
		&& !match_b && !start_b |=> cnt_b_reg == $past(cnt_b_reg) + 8'h01)
		else $error("event edge not counted");

	chk_div_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
		run_a && mode_a == `TMR_M_DIV ##1 run_a && mode_a == `TMR_M_DIV
		|-> out_a_reg == ~$past(ff_a_reg))
		else $error("divider pin not inverse of flip-flop");

	chk_casc_carry: assert property (@(posedge ref_clk) disable iff (!rst_n)
		casc && !start_b && cnt_b_reg != $past(cnt_b_reg) && $past(casc) && !$past(start_b)
		|-> $past(inc_a) && ($past(cnt_a_reg) == `TMR_ONES8 || $past(match16)))
		else $error("upper byte moved without carry");

	chk_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
		irq_reg == |(status_reg & $past(mask_reg)) || $past(!rst_n))
		else $error("interrupt level wrong");

	chk_read_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd && addr == `TMR_OFF_STATUS && !ev_a && !ev_b |=> status_reg == 2'h0)
		else $error("status read did not clear");
endmodule // tmr_top

// *** verif/tmr_top_tb.sv ***
/*
  Self-checking testbench for the dual cascadable timer: reset values,
  register access, timer, event, divider and cascaded operation.
  Assumes the design's register port, one ref_clk domain and an async reset.
*/
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tmr_top_tb;
	import tmr_pkg::*;

	// ------------------------------------------------------------------
	// Signals and design instance
	// ------------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	tmr_addr_t addr = 8'h00;
	tmr_byte_t wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic pin_a = 1'b1;
	logic pin_b = 1'b1;
	tmr_byte_t rdata;
	logic out_a;
	logic out_b;
	logic irq;
	int n_errors = 0;
	int tests_run = 0;
	int cycles = 0;

	tmr_top i_tmr_top (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.counter_a_event_pin(pin_a),
		.counter_b_event_pin(pin_b),
		.out_a(out_a),
		.out_b(out_b),
		.irq(irq)
	);

	initial begin
		forever #25 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d.", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wr_reg(input tmr_addr_t a, input tmr_byte_t d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input tmr_addr_t a, input tmr_byte_t exp, input string what);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		check(rdata, exp, what);
	endtask

	task automatic idle(input int c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask

	task automatic wait_irq(input int maxc, output int n);
		n = 0;
		while (irq !== 1'b1 && n < maxc) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
	endtask

	task automatic pulse(input int sel);
		@(posedge ref_clk);
		if (sel == 0) pin_a <= 1'b0;
		else pin_b <= 1'b0;
		repeat (4) @(posedge ref_clk);
		if (sel == 0) pin_a <= 1'b1;
		else pin_b <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset;
		check({7'h00, out_a}, 8'h01, "out_a after reset");
		check({7'h00, out_b}, 8'h01, "out_b after reset");
		check({7'h00, irq}, 8'h00, "irq after reset");
		rd_chk(`TMR_OFF_CTRL_A, `TMR_CTRL_RST, "ctrl a reset");
		rd_chk(`TMR_OFF_CTRL_B, `TMR_CTRL_RST, "ctrl b reset");
		for (int i = 0; i < 4; i++) begin
			rd_chk(`TMR_OFF_PER_A + 8'(i), `TMR_CMP_RST, "compare reset");
		end
		rd_chk(8'h30, 8'h00, "unmapped read");
	endtask

	task automatic t_regs;
		for (int i = 0; i < 4; i++) begin
			wr_reg(`TMR_OFF_PER_A + 8'(i), 8'h5A ^ 8'(i));
		end
		for (int i = 0; i < 4; i++) begin
			rd_chk(`TMR_OFF_PER_A + 8'(i), 8'h5A ^ 8'(i), "compare readback");
		end
		wr_reg(8'h30, 8'hFF);
		wr_reg(`TMR_OFF_CTRL_A, 8'hF5);
		wr_reg(`TMR_OFF_CTRL_B, 8'hE7);
		rd_chk(`TMR_OFF_CTRL_A, 8'hF5, "ctrl a readback");
		rd_chk(`TMR_OFF_CTRL_B, 8'hE7, "ctrl b readback");
		rd_chk(8'h30, 8'h00, "unmapped after write");
		wr_reg(`TMR_OFF_CTRL_A, 8'h00);
		wr_reg(`TMR_OFF_CTRL_B, 8'h00);
	endtask

	task automatic t_timer;
		int n;
		wr_reg(`TMR_OFF_PER_A, 8'h02);
		wr_reg(`TMR_OFF_MASK, 8'h00);
		wr_reg(`TMR_OFF_CTRL_A, 8'h38);
		idle(40);
		check({7'h00, irq}, 8'h00, "masked irq");
		wr_reg(`TMR_OFF_MASK, 8'h01);
		idle(2);
		check({7'h00, irq}, 8'h01, "unmasked irq");
		wr_reg(`TMR_OFF_CTRL_A, 8'hC5);
		rd_chk(`TMR_OFF_CTRL_A, 8'h30, "stop keeps fields");
		rd_chk(`TMR_OFF_STATUS, 8'h01, "status set");
		rd_chk(`TMR_OFF_STATUS, 8'h00, "status cleared");
		check({7'h00, irq}, 8'h00, "irq after clear");
		for (int h = 0; h < 2; h++) begin
			wr_reg(`TMR_OFF_SYS, 8'(h));
			wr_reg(`TMR_OFF_CTRL_A, 8'h38);
			wait_irq(100, n);
			check(8'(n >= 16 * (h + 1) - 1 && n <= 25 * (h + 1) + 2), 8'h01, "match time");
			wr_reg(`TMR_OFF_CTRL_A, 8'h30);
			rd_chk(`TMR_OFF_STATUS, 8'h01, "status per run");
		end
		wr_reg(`TMR_OFF_SYS, 8'h00);
		wr_reg(`TMR_OFF_CTRL_A, 8'h48);
		idle(100);
		rd_chk(`TMR_OFF_STATUS, 8'h00, "code 4 no ticks");
		wr_reg(`TMR_OFF_CTRL_A, 8'h40);
	endtask

	task automatic t_event(input int sel);
		tmr_byte_t bit_m;
		bit_m = 8'h01 << sel;
		wr_reg(sel == 0 ? `TMR_OFF_PER_A : `TMR_OFF_PER_B, 8'h03);
		wr_reg(`TMR_OFF_MASK, bit_m);
		wr_reg(`TMR_OFF_CTRL_A + 8'(sel), 8'h78);
		repeat (3) pulse(sel);
		check({7'h00, irq}, 8'h00, "no match before period");
		pulse(sel);
		idle(4);
		check({7'h00, irq}, 8'h01, "match on fourth fall");
		wr_reg(`TMR_OFF_CTRL_A + 8'(sel), 8'h70);
		rd_chk(`TMR_OFF_STATUS, bit_m, "event status");
	endtask

	task automatic t_divider;
		int n;
		wr_reg(`TMR_OFF_PER_A, 8'h01);
		wr_reg(`TMR_OFF_CTRL_A, 8'hB9);
		idle(3);
		check({7'h00, out_a}, 8'h00, "pin is inverted flop");
		n = 0;
		while (out_a !== 1'b1 && n < 40) begin
			idle(1);
			n++;
		end
		check(8'(n < 40), 8'h01, "divider toggles");
		wr_reg(`TMR_OFF_CTRL_A, 8'h31);
		rd_chk(`TMR_OFF_STATUS, 8'h01, "divider status");
	endtask

	task automatic t_cascade;
		int n;
		wr_reg(`TMR_OFF_PER_A, 8'h01);
		wr_reg(`TMR_OFF_PER_B, 8'h01);
		wr_reg(`TMR_OFF_MASK, 8'h02);
		wr_reg(`TMR_OFF_CTRL_A, 8'h33);
		wr_reg(`TMR_OFF_CTRL_B, 8'h0C);
		wait_irq(2200, n);
		check(8'(n >= 257 * 8 + 1 && n <= 257 * 8 + 8), 8'h01, "cascaded match");
		check({7'h00, out_a}, 8'h01, "out_a idle when cascaded");
		wr_reg(`TMR_OFF_CTRL_B, 8'h04);
		rd_chk(`TMR_OFF_STATUS, 8'h02, "cascaded status");
	endtask

	task automatic t_ppg;
		int n;
		int lo;
		wr_reg(`TMR_OFF_PER_A, 8'h06);
		wr_reg(`TMR_OFF_PER_B, 8'h00);
		wr_reg(`TMR_OFF_DUTY_A, 8'h02);
		wr_reg(`TMR_OFF_DUTY_B, 8'h00);
		wr_reg(`TMR_OFF_CTRL_B, 8'h0F);
		wait_irq(100, n);
		check(8'(n >= 1 && n <= 64), 8'h01, "pulse period match");
		lo = 0;
		repeat (112) begin
			idle(1);
			lo += (out_b === 1'b0);
		end
		check(8'(lo), 8'h40, "pulse low time");
		wr_reg(`TMR_OFF_CTRL_B, 8'h07);
		rd_chk(`TMR_OFF_STATUS, 8'h02, "pulse status");
	endtask

	task automatic t_pwm;
		int n;
		int hi;
		wr_reg(`TMR_OFF_DUTY_A, 8'h40);
		wr_reg(`TMR_OFF_MASK, 8'h01);
		wr_reg(`TMR_OFF_CTRL_A, 8'h3A);
		wait_irq(2100, n);
		check(8'(n >= 255 * 8 + 1 && n <= 255 * 8 + 8), 8'h01, "pwm overflow");
		hi = 0;
		repeat (2048) begin
			idle(1);
			hi += (out_a === 1'b1);
		end
		check(8'(hi / 8), 8'h40, "pwm high ticks");
		check(8'(hi % 8), 8'h00, "pwm whole ticks");
		wr_reg(`TMR_OFF_CTRL_A, 8'h32);
		rd_chk(`TMR_OFF_STATUS, 8'h01, "pwm status");
	endtask

	// ------------------------------------------------------------------
	// Main sequence and timeout
	// ------------------------------------------------------------------
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		t_reset();
		t_regs();
		t_timer();
		t_event(0);
		t_event(1);
		t_divider();
		t_cascade();
		t_ppg();
		t_pwm();
		give_verdict();
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			$display("[FAIL] %0t run did not finish in time", $time);
			give_verdict();
		end
	end
endmodule // tmr_top_tb
